// >>> pkg/hcct_pkg.sv
// Constants shared by the check-capture, length-counter and test-control logic
package hcct_pkg;
	localparam int         DW             = 8;
	localparam int         AW             = 5;
	// Register offsets on the processor port
	localparam logic [4:0] OFF_CHECK_HIGH = 5'h18;
	localparam logic [4:0] OFF_CHECK_LOW  = 5'h19;
	localparam logic [4:0] OFF_TX_LENGTH  = 5'h1a;
	localparam logic [4:0] OFF_TEST_CTRL  = 5'h1b;
	// Test control bit positions
	localparam int         BIT_SOFT_RST   = 7;
	localparam int         BIT_LOOPBACK   = 6;
	localparam int         BIT_FIFO_TEST  = 2;
	// Writable test bits: 7..1, bit 0 unused
	localparam logic [7:0] TEST_WR_MASK   = 8'hfe;
	// Values after reset
	localparam logic [7:0] RST_TX_LENGTH  = 8'h00;
	localparam logic [7:0] RST_TEST_CTRL  = 8'h00;
	localparam logic [7:0] RST_CHECK      = 8'h00;
	localparam logic [7:0] UNMAPPED_READ  = 8'h00;
	// Count at which the next transmit write is tagged as packet end
	localparam logic [7:0] COUNT_LAST     = 8'h01;
	localparam logic [7:0] COUNT_IDLE     = 8'h00;
endpackage

// >>> rtl/hcct_check_capture.sv
// Captures the received check sequence bit by bit and latches it at packet end
`timescale 1ns/100ps
module hcct_check_capture (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_bit_valid,
	input  wire logic       i_bit,
	input  wire logic       i_pkt_end,
	output logic [7:0]      o_check_high,
	output logic [7:0]      o_check_low
);
	logic [15:0] shift_q;
	logic [15:0] shift_d;
	logic [15:0] hold_q;
	logic [15:0] hold_d;

	// First bit on the line ends in bit 15; no re-inversion is done
	assign shift_d = i_bit_valid ? {shift_q[14:0], i_bit} : shift_q; // R3
	// A bit arriving with the end strobe still belongs to this packet
	assign hold_d  = i_pkt_end ? shift_d : hold_q; // R4

	// Shift and latch registers
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			shift_q <= {hcct_pkg::RST_CHECK, hcct_pkg::RST_CHECK};
			hold_q  <= {hcct_pkg::RST_CHECK, hcct_pkg::RST_CHECK};
		end else begin
			shift_q <= shift_d;
			hold_q  <= hold_d;
		end
	end

	assign o_check_high = hold_q[15:8]; // R1
	assign o_check_low  = hold_q[7:0]; // R2

	// Latched value only changes at a packet end
	property p_hold_stable;
		@(posedge i_mclk) disable iff (i_rst)
		!i_pkt_end |=> $stable(hold_q);
	endproperty
	a_hold_stable: assert property (p_hold_stable) else $error("check latch moved"); // R4

	// Line bit arriving with the end strobe is latched in bit 0 of the low byte
	property p_msb_first;
		@(posedge i_mclk) disable iff (i_rst)
		(i_pkt_end && i_bit_valid) |=> (o_check_low[0] == $past(i_bit));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("check bit order wrong"); // R3
endmodule

// >>> rtl/hcct_len_counter.sv
// Transmit length counter that tags the final byte of each packet
`timescale 1ns/100ps
module hcct_len_counter (
	input  wire logic       i_mclk,
	input  wire logic       i_rst,
	input  wire logic       i_load,
	input  wire logic [7:0] i_load_val,
	input  wire logic       i_cycle_en,
	input  wire logic       i_fifo_wr,
	output logic [7:0]      o_count,
	output logic            o_end_tag
);
	logic [7:0] count_q;
	logic [7:0] count_d;
	logic [7:0] reload_q;
	logic [7:0] reload_d;
	logic       at_last;

	assign at_last   = (count_q == hcct_pkg::COUNT_LAST);
	assign o_end_tag = at_last; // R6
	assign o_count   = count_q;

	// Software load wins over a write completing in the same cycle
	assign count_d =
		i_load                            ? i_load_val :
		!i_fifo_wr                        ? count_q :
		(at_last && i_cycle_en)           ? reload_q : // R8
		(count_q == hcct_pkg::COUNT_IDLE) ? count_q : // R18
		count_q - 8'h01; // R7
	assign reload_d = i_load ? i_load_val : reload_q;

	// Counter and programmed length
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			count_q  <= hcct_pkg::RST_TX_LENGTH; // R5
			reload_q <= hcct_pkg::RST_TX_LENGTH;
		end else begin
			count_q  <= count_d;
			reload_q <= reload_d;
		end
	end

	// A write at one with cycling on brings back the programmed length
	property p_reload;
		@(posedge i_mclk) disable iff (i_rst)
		(i_fifo_wr && !i_load && at_last && i_cycle_en) |=> (count_q == $past(reload_q));
	endproperty
	a_reload: assert property (p_reload) else $error("length did not reload"); // R8

	// Without cycling the counter parks at zero
	property p_park;
		@(posedge i_mclk) disable iff (i_rst)
		(i_fifo_wr && !i_load && at_last && !i_cycle_en) |=> (count_q == 8'h00);
	endproperty
	a_park: assert property (p_park) else $error("length did not stop at zero"); // R18
endmodule

// >>> rtl/hcct_top.sv
// HDLC check capture, transmit length counter and test control register
// Summary of operation
// R1: Read-only byte holds captured check high bits
// R2: Read-only byte holds captured check low bits
// R3: Check bits stored MSB first, still inverted
// R4: Both check bytes update at packet end
// R5: Eight-bit writable length counter, zero at reset
// R6: Count of one tags next write as end
// R7: Counter decrements after each transmit FIFO write; here only processor writes count, looped bytes do not
// R8: Cycle bit reloads programmed length after end
// R9: Test bit 7 resets controller like reset
// R10: Soft reset clears after two zero writes
// R11: Bit 6 copies received bytes into transmit FIFO
// R12: Looped bytes transmitted; good and bad packets
// R13: Software may loop by copying FIFO bytes
// R14: Bit 2 swaps processor FIFO write and read
// R15: Test mode routes tags; readback shows transmit tags
// R16: Software keeps test bits 5,4,3,1 zero
// R17: Cycle bit from control register two input
// R18: Without cycling counter stops at zero
`timescale 1ns/100ps
module hcct_top (
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	// Processor register port
	input  wire logic [4:0] i_addr,
	input  wire logic       i_wr_en,
	input  wire logic       i_rd_en,
	input  wire logic [7:0] i_wdata,
	output logic [7:0]      o_rdata,
	// Cycle control bit from the second control register
	input  wire logic       i_cycle_en,
	// Receiver side: check bits and packet end
	input  wire logic       i_rcv_check_valid,
	input  wire logic       i_rcv_check_bit,
	input  wire logic       i_rcv_pkt_end,
	// Receiver writes into the receive FIFO
	input  wire logic       i_rcv_wr,
	input  wire logic [7:0] i_rcv_data,
	input  wire logic       i_rcv_packet_end_tag,
	input  wire logic       i_rcv_frame_abort_tag,
	// Processor writes aimed at the transmit FIFO
	input  wire logic       i_cpu_txf_wr,
	input  wire logic [7:0] i_cpu_txf_data,
	input  wire logic       i_cpu_frame_abort_tag,
	input  wire logic       i_cpu_packet_end_tag,
	output logic            o_cpu_txf_ready,
	// Processor reads aimed at the receive FIFO
	input  wire logic       i_cpu_rxf_rd,
	output logic [7:0]      o_cpu_fifo_q,
	output logic [1:0]      o_fifo_tag_readback_bits,
	// Heads of both FIFOs
	input  wire logic [7:0] i_rxf_head,
	input  wire logic [1:0] i_rxf_head_tags,
	input  wire logic [7:0] i_txf_head,
	input  wire logic [1:0] i_txf_head_tags,
	// Transmit FIFO write and read
	output logic            o_txf_wr,
	output logic [7:0]      o_txf_data,
	output logic            o_txf_packet_end_tag,
	output logic            o_txf_frame_abort_tag,
	output logic            o_txf_rd,
	// Receive FIFO write and read
	output logic            o_rxf_wr,
	output logic [7:0]      o_rxf_data,
	output logic            o_rxf_packet_end_tag,
	output logic            o_rxf_frame_abort_tag,
	output logic            o_rxf_rd,
	// Reset to the rest of the controller
	output logic            o_ctl_rst
);
	logic [7:0] test_q;
	logic [7:0] test_d;
	logic       zero_seen_q;
	logic       zero_seen_d;
	logic       ctl_rst;
	logic       soft_rst;
	logic       loop_en;
	logic       fifo_test;
	logic       wr_test;
	logic       wr_length;
	logic [7:0] check_high;
	logic [7:0] check_low;
	logic [7:0] tx_length_count;
	logic       count_end_tag;
	logic       cpu_txf_go;
	logic       loop_wr;
	logic       cpu_tx_count;
	logic [7:0] reg_sel;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic [7:0] fifo_q_q;
	logic [7:0] fifo_q_d;
	logic [1:0] tags_q;
	logic [1:0] tags_d;

	// Address decode shared by write and read paths
	function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
		hit = (a == off);
	endfunction

	assign wr_test   = i_wr_en && hit(i_addr, hcct_pkg::OFF_TEST_CTRL);
	assign wr_length = i_wr_en && hit(i_addr, hcct_pkg::OFF_TX_LENGTH);

	// Test control fields
	assign soft_rst  = test_q[hcct_pkg::BIT_SOFT_RST];
	assign loop_en   = test_q[hcct_pkg::BIT_LOOPBACK];
	assign fifo_test = test_q[hcct_pkg::BIT_FIFO_TEST];

	// Soft reset acts like the reset pin on capture, counter and FIFO strobes, but not on this register or the read data registers
	assign ctl_rst   = i_sys_rst || soft_rst; // R9
	assign o_ctl_rst = ctl_rst; // R9

	// Soft reset bit survives one zero write; the second one clears it
	always_comb begin
		test_d      = test_q;
		zero_seen_d = zero_seen_q;
		if (wr_test) begin
			test_d = i_wdata & hcct_pkg::TEST_WR_MASK;
			if (!i_wdata[hcct_pkg::BIT_SOFT_RST]) begin
				zero_seen_d = !zero_seen_q; // R10
				test_d[hcct_pkg::BIT_SOFT_RST] = soft_rst && !zero_seen_q; // R10
			end else begin
				zero_seen_d = 1'b0;
			end
		end
	end

	// Test register: cleared only by the pin, never by itself
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			test_q      <= hcct_pkg::RST_TEST_CTRL; // R10
			zero_seen_q <= 1'b0;
		end else begin
			test_q      <= test_d;
			zero_seen_q <= zero_seen_d;
		end
	end

	// Check sequence capture
	hcct_check_capture u_capture (
		.i_mclk       (i_mclk),
		.i_rst        (ctl_rst),
		.i_bit_valid  (i_rcv_check_valid),
		.i_bit        (i_rcv_check_bit),
		.i_pkt_end    (i_rcv_pkt_end),
		.o_check_high (check_high),
		.o_check_low  (check_low)
	);

	// Length counter advances only on processor writes that reach the transmit FIFO
	assign cpu_tx_count = cpu_txf_go && !fifo_test; // R7
	hcct_len_counter u_length (
		.i_mclk     (i_mclk),
		.i_rst      (ctl_rst),
		.i_load     (wr_length),
		.i_load_val (i_wdata),
		.i_cycle_en (i_cycle_en), // R17
		.i_fifo_wr  (cpu_tx_count),
		.o_count    (tx_length_count),
		.o_end_tag  (count_end_tag)
	);

	// Looped receive bytes take the transmit FIFO port; processor waits meanwhile
	assign loop_wr         = loop_en && !fifo_test && i_rcv_wr && !ctl_rst; // R11
	assign o_cpu_txf_ready = !loop_wr;
	assign cpu_txf_go      = i_cpu_txf_wr && !loop_wr && !ctl_rst;

	// Transmit FIFO input: looped byte, or processor byte outside test mode
	assign o_txf_wr = loop_wr || (cpu_txf_go && !fifo_test); // R12
	assign o_txf_data = loop_wr ? i_rcv_data : i_cpu_txf_data; // R12
	assign o_txf_packet_end_tag = loop_wr ? i_rcv_packet_end_tag :
		(i_cpu_packet_end_tag || count_end_tag); // R6
	assign o_txf_frame_abort_tag = loop_wr ? i_rcv_frame_abort_tag :
		i_cpu_frame_abort_tag;

	// Receive FIFO input: processor write in test mode, else receiver
	assign o_rxf_wr = fifo_test ? cpu_txf_go : (i_rcv_wr && !ctl_rst); // R14
	assign o_rxf_data = fifo_test ? i_cpu_txf_data : i_rcv_data; // R14
	assign o_rxf_packet_end_tag = fifo_test ? i_cpu_packet_end_tag :
		i_rcv_packet_end_tag; // R15
	assign o_rxf_frame_abort_tag = fifo_test ? i_cpu_frame_abort_tag :
		i_rcv_frame_abort_tag; // R15

	// Processor FIFO read steered to one FIFO or the other
	assign o_rxf_rd = i_cpu_rxf_rd && !fifo_test && !ctl_rst;
	assign o_txf_rd = i_cpu_rxf_rd && fifo_test && !ctl_rst; // R14
	assign fifo_q_d = !i_cpu_rxf_rd ? fifo_q_q :
		(fifo_test ? i_txf_head : i_rxf_head); // R14
	assign tags_d = !i_cpu_rxf_rd ? tags_q :
		(fifo_test ? i_txf_head_tags : i_rxf_head_tags); // R15

	// Register read select; unmapped offsets read zero
	assign reg_sel =
		hit(i_addr, hcct_pkg::OFF_CHECK_HIGH) ? check_high : // R1
		hit(i_addr, hcct_pkg::OFF_CHECK_LOW)  ? check_low : // R2
		hit(i_addr, hcct_pkg::OFF_TX_LENGTH)  ? tx_length_count : // R5
		hit(i_addr, hcct_pkg::OFF_TEST_CTRL)  ? test_q :
		hcct_pkg::UNMAPPED_READ;
	assign rdata_d = i_rd_en ? reg_sel : rdata_q;

	// Read data held until the next read
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rdata_q  <= hcct_pkg::UNMAPPED_READ;
			fifo_q_q <= hcct_pkg::UNMAPPED_READ;
			tags_q   <= 2'h0;
		end else begin
			rdata_q  <= rdata_d;
			fifo_q_q <= fifo_q_d;
			tags_q   <= tags_d;
		end
	end

	assign o_rdata                  = rdata_q;
	assign o_cpu_fifo_q             = fifo_q_q;
	assign o_fifo_tag_readback_bits = tags_q;

	// Soft reset drives the controller reset and clears counter and capture
	property p_soft_rst;
		@(posedge i_mclk) disable iff (i_sys_rst)
		soft_rst |-> o_ctl_rst ##1
			(tx_length_count == hcct_pkg::RST_TX_LENGTH && check_high == hcct_pkg::RST_CHECK);
	endproperty
	a_soft_rst: assert property (p_soft_rst) else $error("soft reset not applied"); // R9

	// A single zero write after setting leaves soft reset on
	property p_one_zero;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(soft_rst && !zero_seen_q && wr_test && !i_wdata[7]) |=> soft_rst;
	endproperty
	a_one_zero: assert property (p_one_zero) else $error("soft reset cleared too early"); // R10

	// Soft reset never drops without a write
	property p_no_self_clear;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(soft_rst && !wr_test) |=> soft_rst;
	endproperty
	a_no_self_clear: assert property (p_no_self_clear) else $error("soft reset self cleared"); // R10

	// Loopback copies each received byte into the transmit FIFO
	property p_loop_copy;
		@(posedge i_mclk) disable iff (ctl_rst)
		(loop_en && !fifo_test && i_rcv_wr) |->
			(o_txf_wr && o_rxf_wr && o_txf_data == i_rcv_data &&
			 o_txf_packet_end_tag == i_rcv_packet_end_tag);
	endproperty
	a_loop_copy: assert property (p_loop_copy) else $error("loopback byte missing"); // R11

	// Test mode sends processor writes to the receive FIFO only
	property p_test_write;
		@(posedge i_mclk) disable iff (ctl_rst)
		(fifo_test && i_cpu_txf_wr) |->
			(o_rxf_wr && !o_txf_wr && o_rxf_data == i_cpu_txf_data);
	endproperty
	a_test_write: assert property (p_test_write) else $error("test write misrouted"); // R14

	// Test mode read returns transmit head and its tags
	property p_test_read;
		@(posedge i_mclk) disable iff (ctl_rst)
		(fifo_test && i_cpu_rxf_rd) |=>
			(o_cpu_fifo_q == $past(i_txf_head) &&
			 o_fifo_tag_readback_bits == $past(i_txf_head_tags));
	endproperty
	a_test_read: assert property (p_test_read) else $error("test read misrouted"); // R15

	// Processor write at count one carries the end tag
	property p_end_tag;
		@(posedge i_mclk) disable iff (ctl_rst)
		(cpu_tx_count && !loop_wr && tx_length_count == 8'h01) |-> o_txf_packet_end_tag;
	endproperty
	a_end_tag: assert property (p_end_tag) else $error("end tag missing"); // R6

	// Counter steps down by one after a write above one
	property p_decrement;
		@(posedge i_mclk) disable iff (ctl_rst)
		(cpu_tx_count && !wr_length && tx_length_count > 8'h01) |=>
			(tx_length_count == $past(tx_length_count) - 8'h01);
	endproperty
	a_decrement: assert property (p_decrement) else $error("counter did not decrement"); // R7

	// Check high byte read returns captured value one cycle on
	property p_read_high;
		@(posedge i_mclk) disable iff (ctl_rst)
		(i_rd_en && i_addr == 5'h18) |=> (o_rdata == $past(check_high));
	endproperty
	a_read_high: assert property (p_read_high) else $error("check high read wrong"); // R1

	// Check low byte read returns captured value
	property p_read_low;
		@(posedge i_mclk) disable iff (ctl_rst)
		(i_rd_en && i_addr == hcct_pkg::OFF_CHECK_LOW) |=> (o_rdata == $past(check_low));
	endproperty
	a_read_low: assert property (p_read_low) else $error("check low read wrong"); // R2

	// Length read shows the live count
	property p_read_length;
		@(posedge i_mclk) disable iff (ctl_rst)
		(i_rd_en && i_addr == hcct_pkg::OFF_TX_LENGTH) |=> (o_rdata == $past(tx_length_count));
	endproperty
	a_read_length: assert property (p_read_length) else $error("length read wrong"); // R5

	// Looped byte takes the port; a processor write that cycle is held off
	property p_loop_stall;
		@(posedge i_mclk) disable iff (ctl_rst)
		(loop_wr && i_cpu_txf_wr) |-> (!o_cpu_txf_ready && o_txf_data == i_rcv_data);
	endproperty
	a_loop_stall: assert property (p_loop_stall) else $error("loop stall broken"); // R12

	// Looped bytes never move the length counter
	property p_loop_no_count;
		@(posedge i_mclk) disable iff (ctl_rst)
		(loop_wr && !wr_length) |=> $stable(tx_length_count);
	endproperty
	a_loop_no_count: assert property (p_loop_no_count) else $error("loop byte counted"); // R11
endmodule

// >>> tb/hcct_far_station.sv
// Remote station model driving the receiver side of the block
`timescale 1ns/100ps
module hcct_far_station (
	input  wire logic       i_mclk,
	output logic            o_check_valid,
	output logic            o_check_bit,
	output logic            o_pkt_end,
	output logic            o_wr,
	output logic [7:0]      o_data,
	output logic            o_pe,
	output logic            o_fa
);
	// Quiet line at time zero
	initial begin
		{o_check_valid, o_check_bit, o_pkt_end, o_wr, o_pe, o_fa} = '0;
		o_data = 8'h00;
	end
	// One received byte with its tags, left raised until idle() drops it
	task automatic put_byte(input logic [7:0] d, input logic pe, input logic fa);
		@(posedge i_mclk);
		o_wr   <= 1'b1;
		o_data <= d;
		o_pe   <= pe;
		o_fa   <= fa;
	endtask
	// Released data shows the inverse so a stale byte never matches
	task automatic idle();
		@(posedge i_mclk);
		o_wr   <= 1'b0;
		o_pe   <= 1'b0;
		o_fa   <= 1'b0;
		o_data <= ~o_data;
	endtask
	// Check sequence sent MSB first, already inverted by the sender
	task automatic send_check(input logic [15:0] c);
		for (int i = 15; i >= 0; i--) begin
			@(posedge i_mclk);
			o_check_valid <= 1'b1;
			o_check_bit   <= c[i];
			o_pkt_end     <= (i == 0);
		end
		@(posedge i_mclk);
		o_check_valid <= 1'b0;
		o_pkt_end     <= 1'b0;
		o_check_bit   <= ~c[0];
	endtask
endmodule

// >>> tb/tb_hcct_top.sv
// Self-checking bench for check capture, length counter and test control
`timescale 1ns/100ps
module tb_hcct_top;
	logic       i_mclk, i_sys_rst, i_wr_en, i_rd_en, i_cycle_en, i_cpu_txf_wr, i_cpu_rxf_rd;
	logic       i_cpu_frame_abort_tag, i_cpu_packet_end_tag, o_cpu_txf_ready, o_ctl_rst;
	logic [4:0] i_addr;
	logic [7:0] i_wdata, i_cpu_txf_data, i_rxf_head, i_txf_head, o_rdata, o_cpu_fifo_q;
	logic [1:0] i_rxf_head_tags, i_txf_head_tags, o_fifo_tag_readback_bits;
	logic       cv, cb, pk_end, r_wr, r_pe, r_fa, t_wr, t_pe, t_fa, t_rd, x_wr, x_pe, x_fa, x_rd;
	logic [7:0] r_data, t_data, x_data;
	int         err_count = 0;
	int         checks = 0;

	hcct_top dut_u (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_wdata(i_wdata), .o_rdata(o_rdata),
		.i_cycle_en(i_cycle_en), .i_rcv_check_valid(cv), .i_rcv_check_bit(cb),
		.i_rcv_pkt_end(pk_end), .i_rcv_wr(r_wr), .i_rcv_data(r_data),
		.i_rcv_packet_end_tag(r_pe), .i_rcv_frame_abort_tag(r_fa),
		.i_cpu_txf_wr(i_cpu_txf_wr), .i_cpu_txf_data(i_cpu_txf_data),
		.i_cpu_frame_abort_tag(i_cpu_frame_abort_tag),
		.i_cpu_packet_end_tag(i_cpu_packet_end_tag), .o_cpu_txf_ready(o_cpu_txf_ready),
		.i_cpu_rxf_rd(i_cpu_rxf_rd), .o_cpu_fifo_q(o_cpu_fifo_q),
		.o_fifo_tag_readback_bits(o_fifo_tag_readback_bits), .i_rxf_head(i_rxf_head),
		.i_rxf_head_tags(i_rxf_head_tags), .i_txf_head(i_txf_head),
		.i_txf_head_tags(i_txf_head_tags), .o_txf_wr(t_wr), .o_txf_data(t_data),
		.o_txf_packet_end_tag(t_pe), .o_txf_frame_abort_tag(t_fa), .o_txf_rd(t_rd),
		.o_rxf_wr(x_wr), .o_rxf_data(x_data), .o_rxf_packet_end_tag(x_pe),
		.o_rxf_frame_abort_tag(x_fa), .o_rxf_rd(x_rd), .o_ctl_rst(o_ctl_rst));

	hcct_far_station far_u (.i_mclk(i_mclk), .o_check_valid(cv), .o_check_bit(cb),
		.o_pkt_end(pk_end), .o_wr(r_wr), .o_data(r_data), .o_pe(r_pe), .o_fa(r_fa));

	// 20 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_wr_en <= 1'b1;
		i_addr  <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr_en <= 1'b0;
	endtask
	// Registered answer is looked at in the cycle after the read edge
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		@(posedge i_mclk);
		i_rd_en <= 1'b1;
		i_addr  <= a;
		@(posedge i_mclk);
		i_rd_en <= 1'b0;
		@(negedge i_mclk);
		cmp(o_rdata, exp);
	endtask
	// Processor transmit write; strobes are combinational so sample mid-cycle
	task automatic txw(input logic [7:0] d, input logic wr_exp, input logic tag_exp);
		@(posedge i_mclk);
		i_cpu_txf_wr   <= 1'b1;
		i_cpu_txf_data <= d;
		@(negedge i_mclk);
		cmp({t_wr, o_cpu_txf_ready}, {wr_exp, 1'b1});
		if (wr_exp) cmp({t_pe, t_data}, {tag_exp, d});
		@(posedge i_mclk);
		i_cpu_txf_wr <= 1'b0;
	endtask
	task automatic fifo_rd(input logic [1:0] strobes, input logic [9:0] q);
		@(posedge i_mclk);
		i_cpu_rxf_rd <= 1'b1;
		@(negedge i_mclk);
		cmp({t_rd, x_rd}, strobes);
		@(posedge i_mclk);
		i_cpu_rxf_rd <= 1'b0;
		@(negedge i_mclk);
		cmp({o_fifo_tag_readback_bits, o_cpu_fifo_q}, q);
	endtask
	task automatic final_report();
		$display("checks=%0d err_count=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Watchdog far beyond the roughly 140 cycles the sequence needs
	initial begin
		repeat (5000) @(posedge i_mclk);
		err_count++;
		final_report();
	end

	// Main sequence
	initial begin
		{i_wr_en, i_rd_en, i_cycle_en, i_cpu_txf_wr, i_cpu_rxf_rd} = '0;
		{i_cpu_frame_abort_tag, i_cpu_packet_end_tag, i_addr, i_wdata, i_cpu_txf_data} = '0;
		{i_rxf_head, i_rxf_head_tags, i_txf_head, i_txf_head_tags} = {8'h96, 2'b01, 8'he7, 2'b10};
		i_sys_rst = 1'b1;
		repeat (6) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		rd(hcct_pkg::OFF_TX_LENGTH, 8'h00);
		rd(hcct_pkg::OFF_TEST_CTRL, 8'h00);
		rd(5'h03, 8'h00);
		far_u.send_check(16'ha5c3);
		rd(hcct_pkg::OFF_CHECK_HIGH, 8'ha5);
		rd(hcct_pkg::OFF_CHECK_LOW, 8'hc3);
		wr(hcct_pkg::OFF_CHECK_HIGH, 8'h11);
		rd(hcct_pkg::OFF_CHECK_HIGH, 8'ha5);
		far_u.send_check(16'h3c96);
		rd(hcct_pkg::OFF_CHECK_HIGH, 8'h3c);
		rd(hcct_pkg::OFF_CHECK_LOW, 8'h96);
		// Counting down to the tagged byte, then parking at zero
		wr(hcct_pkg::OFF_TX_LENGTH, 8'h02);
		txw(8'h10, 1'b1, 1'b0);
		rd(hcct_pkg::OFF_TX_LENGTH, 8'h01);
		txw(8'h11, 1'b1, 1'b1);
		rd(hcct_pkg::OFF_TX_LENGTH, 8'h00);
		txw(8'h12, 1'b1, 1'b0);
		rd(hcct_pkg::OFF_TX_LENGTH, 8'h00);
		@(posedge i_mclk);
		i_cycle_en <= 1'b1;
		wr(hcct_pkg::OFF_TX_LENGTH, 8'h02);
		for (int k = 0; k < 4; k++) txw({4'h2, 4'(k)}, 1'b1, k[0]);
		rd(hcct_pkg::OFF_TX_LENGTH, 8'h02);
		@(posedge i_mclk);
		i_cycle_en <= 1'b0;
		wr(hcct_pkg::OFF_TX_LENGTH, 8'hff);
		// Loopback copies good and aborted bytes without counting them
		wr(hcct_pkg::OFF_TEST_CTRL, 8'h40);
		for (int k = 0; k < 2; k++) begin
			far_u.put_byte({7'h2d, k[0]}, ~k[0], k[0]);
			i_cpu_txf_wr <= 1'b1;
			@(negedge i_mclk);
			cmp({t_wr, t_pe, t_fa, t_data}, {1'b1, ~k[0], k[0], 7'h2d, k[0]});
			cmp({x_wr, x_pe, x_fa, x_data}, {1'b1, ~k[0], k[0], 7'h2d, k[0]});
			cmp(o_cpu_txf_ready, 1'b0);
			far_u.idle();
			i_cpu_txf_wr <= 1'b0;
		end
		rd(hcct_pkg::OFF_TX_LENGTH, 8'hff);
		wr(hcct_pkg::OFF_TEST_CTRL, 8'h00);
		far_u.put_byte(8'h77, 1'b1, 1'b0);
		@(negedge i_mclk);
		cmp({t_wr, x_wr}, 2'b01);
		far_u.idle();
		fifo_rd(2'b01, {2'b01, 8'h96});
		// Software loop: copy the read byte back into the transmit FIFO
		txw(8'h96, 1'b1, 1'b0);
		// FIFO test mode swaps processor write and read paths
		wr(hcct_pkg::OFF_TEST_CTRL, 8'h04);
		@(posedge i_mclk);
		{i_cpu_txf_wr, i_cpu_packet_end_tag, i_cpu_frame_abort_tag} <= 3'b111;
		i_cpu_txf_data <= 8'h3c;
		@(negedge i_mclk);
		cmp({x_wr, x_pe, x_fa, t_wr, x_data}, {4'b1110, 8'h3c});
		@(posedge i_mclk);
		{i_cpu_txf_wr, i_cpu_packet_end_tag, i_cpu_frame_abort_tag} <= 3'b000;
		fifo_rd(2'b10, {2'b10, 8'he7});
		rd(hcct_pkg::OFF_TX_LENGTH, 8'hfe);
		// Soft reset holds until two zero writes in a row
		wr(hcct_pkg::OFF_TEST_CTRL, 8'h80);
		@(negedge i_mclk);
		cmp(o_ctl_rst, 1'b1);
		rd(hcct_pkg::OFF_TX_LENGTH, 8'h00);
		rd(hcct_pkg::OFF_CHECK_HIGH, 8'h00);
		wr(hcct_pkg::OFF_TEST_CTRL, 8'h00);
		rd(hcct_pkg::OFF_TEST_CTRL, 8'h80);
		wr(hcct_pkg::OFF_TEST_CTRL, 8'h80);
		wr(hcct_pkg::OFF_TEST_CTRL, 8'h00);
		rd(hcct_pkg::OFF_TEST_CTRL, 8'h80);
		wr(hcct_pkg::OFF_TEST_CTRL, 8'h00);
		rd(hcct_pkg::OFF_TEST_CTRL, 8'h00);
		cmp(o_ctl_rst, 1'b0);
		wr(hcct_pkg::OFF_TEST_CTRL, 8'h80);
		@(posedge i_mclk);
		i_sys_rst <= 1'b1;
		@(posedge i_mclk);
		i_sys_rst <= 1'b0;
		rd(hcct_pkg::OFF_TEST_CTRL, 8'h00);
		final_report();
	end
endmodule
